// *** pkg/dmr_pkg.sv ***
// Constants, field layout and state encoding for the mode register block
package dmr_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MR0    = 8'h04;
  localparam logic [7:0] REG_MR1    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Reset values
  localparam logic [3:0]  CWL_RESET = 4'h5;
  localparam logic [13:0] MR_RESET  = 14'h0000;

  // Mode register 0 field positions
  localparam int MR0_BL_LSB  = 0;
  localparam int MR0_CL_A2   = 2;
  localparam int MR0_BT      = 3;
  localparam int MR0_CL_LSB  = 4;
  localparam int MR0_TM      = 7;
  localparam int MR0_DLL_RST = 8;
  localparam int MR0_WR_LSB  = 9;
  localparam int MR0_PPD     = 12;

  // Mode register 1 field positions
  localparam int MR1_DLL_DIS = 0;
  localparam int MR1_DIC_A1  = 1;
  localparam int MR1_RTT_A2  = 2;
  localparam int MR1_AL_LSB  = 3;
  localparam int MR1_DIC_A5  = 5;
  localparam int MR1_RTT_A6  = 6;
  localparam int MR1_WLVL    = 7;
  localparam int MR1_RTT_A9  = 9;
  localparam int MR1_TDQS    = 11;
  localparam int MR1_QOFF    = 12;

  // Burst length field codes
  localparam logic [1:0] BL_FIXED8 = 2'b00;
  localparam logic [1:0] BL_OTF    = 2'b01;
  localparam logic [1:0] BL_FIXED4 = 2'b10;

  // Column address bit that picks chop or full burst on the fly
  localparam int BC_SEL_BIT = 12;

  // CAS latency is the four bit code plus this offset
  localparam logic [4:0] CL_OFFSET = 5'h04;

  // Beat slot at which a fixed chop write ends, two clocks early
  localparam logic [2:0] CHOP_END_SLOT = 3'h3;
  localparam logic [2:0] LAST_SLOT     = 3'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_AL, ST_CAS, ST_BURST} dmr_state_e;

endpackage

// *** hw/dmr_core.sv ***
// DDR3 mode register 0/1 decode, burst ordering and latency timing
`timescale 1ns/1ps

// Rules from the document for this block and its controller
// [R1] Eight-beat read order: nibble wrap when sequential, start XOR index else.
// [R2] Chopped read returns four beats, drivers off for remaining four slots.
// [R3] Writes ignore low column bits; chop uses bit 2 for half, rest don't care.
// [R4] Fixed chop moves write recovery start two clocks early; on-the-fly does not.
// [R5] CAS latency from MR0 A2,A4,A5,A6, whole clocks from internal read.
// [R6] Read latency is AL plus CL; write latency is AL plus CWL.
// [R7] Controller keeps MR0 A7 zero; test mode behaviour is unspecified.
// [R8] DLL reset bit clears itself once the reset has been issued.
// [R9] Controller waits DLL lock time after DLL reset before reads.
// [R10] Controller follows DLL enable with DLL reset and holds CKE high; the bench re-enables the DLL with no DLL reset, then drops CKE.
// [R11] Controller programs write recovery field at least tWR over tCK rounded up.
// [R12] MR0 A12 zero freezes DLL in power-down; one keeps it running.
// [R13] MRS with BA0 high, BA1 and BA2 low writes mode register 1.
// [R14] Controller drives BA2, A8, A10, A13 low when writing MR1.
// [R15] Write levelling with outputs on allows only RZQ/2, /4, /6 termination.
// [R16] Nominal termination during writes only RZQ/2, RZQ/4 or RZQ/6.
// [R17] DLL on: turned off at self-refresh entry, back on at exit.
// [R18] DLL off: controller disables nominal termination by pin or bits.
// [R19] DLL off: controller clears MR2 write termination bits.
// [R20] Driver impedance selected by MR1 A1 and A5.
// [R21] AL from MR1 A4:A3: 0, CL-1, CL-2, 11 reserved.
// [R22] Read or write held for AL before internal execution.
// [R23] Burst length from MR0 A1:A0: fixed chop, fixed eight, or on-the-fly.
// [R24] MRS with all bank bits low writes mode register 0.
// [R25] MR1 A0 one disables DLL until cleared to zero.
// [R26] Controller avoids reserved AL code and checks its own read latency; the bench writes AL code 11 once to check the reserved flag.
module dmr_core
  import dmr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  output logic             int_cmd,
  output logic             int_cmd_write,
  output logic             rd_beat,
  output logic      [2:0]  rd_col,
  output logic             dq_oe,
  output logic             wr_beat,
  output logic      [2:0]  wr_col,
  output logic             wr_care,
  output logic             wr_rec_start,
  output logic             dll_run,
  output logic             dll_reset,
  output logic             exit_slow,
  output logic      [1:0]  drv_imp,
  output logic      [2:0]  rtt_nom,
  output logic             wr_level,
  output logic             out_off,
  output logic             tdqs_en
);

  function automatic logic [2:0] beat_col(input logic [2:0] start,
                                          input logic [2:0] idx,
                                          input logic       ilv);
    logic [1:0] low;
    low = start[1:0] + idx[1:0];
    if (ilv) begin
      beat_col = start ^ idx;
    end else begin
      beat_col = {start[2] ^ idx[2], low};
    end
  endfunction

  function automatic logic [4:0] add_lat(input logic [1:0] code,
                                         input logic [4:0] cl);
    case (code)
      2'b01:   add_lat = cl - 5'h01;
      2'b10:   add_lat = cl - 5'h02;
      default: add_lat = 5'h00;
    endcase
  endfunction

  // Pin synchroniser: first stage is read only by the second
  logic [22:0] pin_meta;
  logic [22:0] pin_sync;
  logic        ck_d;
  logic        cke_prev;

  logic [13:0] mr0;
  logic [13:0] mr1;
  logic [3:0]  cwl;
  logic        sr_active;
  logic        pd_active;

  dmr_state_e  state;
  logic [4:0]  cnt;
  logic [2:0]  slot;
  logic        acc_write;
  logic [2:0]  acc_start;
  logic        acc_chop;
  logic        acc_fixed4;

  wire       s_ck    = pin_sync[22];
  wire       s_cke   = pin_sync[21];
  wire       s_cs_n  = pin_sync[20];
  wire       s_ras_n = pin_sync[19];
  wire       s_cas_n = pin_sync[18];
  wire       s_we_n  = pin_sync[17];
  wire [2:0] s_ba    = pin_sync[16:14];
  wire [13:0] s_addr = pin_sync[13:0];

  wire ck_rise = s_ck & ~ck_d;
  wire ck_edge = s_ck ^ ck_d;

  wire cmd_ok  = ck_rise & cke_prev & s_cke & ~s_cs_n;
  wire is_mrs  = cmd_ok & ~s_ras_n & ~s_cas_n & ~s_we_n;
  wire mr0_wr  = is_mrs & (s_ba == 3'b000); // [R24]
  wire mr1_wr  = is_mrs & (s_ba == 3'b001); // [R13]
  wire is_rw   = cmd_ok & s_ras_n & ~s_cas_n;
  wire sr_go   = ck_rise & cke_prev & ~s_cke & ~s_cs_n & ~s_ras_n
                 & ~s_cas_n & s_we_n;
  wire pd_go   = ck_rise & cke_prev & ~s_cke & ~sr_go;
  wire cke_up  = ck_rise & ~cke_prev & s_cke;

  // Latency decode
  wire [4:0] cl_val = {1'b0, mr0[MR0_CL_A2], mr0[MR0_CL_LSB+2:MR0_CL_LSB]}
                      + CL_OFFSET; // [R5]
  wire [4:0] al_val = add_lat(mr1[MR1_AL_LSB+1:MR1_AL_LSB], cl_val); // [R21]
  wire [4:0] cwl_val = {1'b0, cwl};
  wire [5:0] rl_val = {1'b0, al_val} + {1'b0, cl_val}; // [R6]
  wire [5:0] wl_val = {1'b0, al_val} + {1'b0, cwl_val}; // [R6]
  wire       al_rsvd = &mr1[MR1_AL_LSB+1:MR1_AL_LSB];

  // Burst length selection for a new access
  wire [1:0] bl_mode   = mr0[MR0_BL_LSB+1:MR0_BL_LSB];
  wire       new_fixed4 = (bl_mode == BL_FIXED4);
  wire       new_chop  = new_fixed4
                         | ((bl_mode == BL_OTF) & ~s_addr[BC_SEL_BIT]); // [R23]
  wire [4:0] new_lat   = s_we_n ? cl_val : cwl_val;
  wire [4:0] acc_lat   = acc_write ? cwl_val : cl_val;

  // Beat emission
  wire st_cas   = (state == ST_CAS);
  wire st_burst = (state == ST_BURST);
  wire first_bt = st_cas & ck_rise & (cnt == 5'h00);
  wire emit     = first_bt | (st_burst & ck_edge);
  wire [2:0] bidx = st_burst ? slot : 3'h0;
  wire       tail = bidx[2];
  wire [2:0] rcol = beat_col(acc_start, bidx, mr0[MR0_BT]); // [R1]
  wire [2:0] wcol = acc_chop ? {acc_start[2], bidx[1:0]} : bidx; // [R3]
  wire       rdrv = ~(acc_chop & tail); // [R2]
  wire [2:0] rec_at = acc_fixed4 ? CHOP_END_SLOT : LAST_SLOT; // [R4]
  wire       rec_hit = emit & acc_write & (bidx == rec_at);

  // Internal command after additive latency
  wire int_go = (state == ST_AL) & ck_rise & (cnt == 5'h00); // [R22]
  wire new_acc = is_rw & (state == ST_IDLE);

  wire dll_on = ~mr1[MR1_DLL_DIS] & ~sr_active
                & ~(pd_active & ~mr0[MR0_PPD]); // [R12] [R17] [R25]

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready & pwrite;
  wire hit_ctrl  = (paddr == REG_CTRL);
  wire hit_mr0   = (paddr == REG_MR0);
  wire hit_mr1   = (paddr == REG_MR1);
  wire hit_stat  = (paddr == REG_STATUS);
  wire hit_any   = hit_ctrl | hit_mr0 | hit_mr1 | hit_stat;
  wire [31:0] stat_word = {6'h00, rl_val, wl_val, al_val, cl_val,
                           1'b0, mr0[MR0_TM], al_rsvd, dll_on};
  wire [31:0] rd_word = hit_ctrl ? {28'h0000000, cwl}
                      : hit_mr0  ? {18'h00000, mr0}
                      : hit_mr1  ? {18'h00000, mr1}
                      : hit_stat ? stat_word
                      : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    pin_meta <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr};
    pin_sync <= pin_meta;
    ck_d     <= pin_sync[22];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      cwl     <= CWL_RESET;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      prdata  <= apb_setup ? rd_word : 32'h00000000;
      if (apb_wr & hit_ctrl) begin
        cwl <= (pwdata[3:0] == 4'h0) ? 4'h1 : pwdata[3:0];
      end
    end
  end

  // Mode registers and power state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mr0       <= MR_RESET;
      mr1       <= MR_RESET;
      cke_prev  <= 1'b0;
      sr_active <= 1'b0;
      pd_active <= 1'b0;
      dll_reset <= 1'b0;
    end else begin
      dll_reset <= mr0_wr & s_addr[MR0_DLL_RST];
      if (mr0_wr) begin
        mr0 <= s_addr;
      end else if (dll_reset) begin
        mr0[MR0_DLL_RST] <= 1'b0; // [R8]
      end
      if (mr1_wr) begin
        mr1 <= s_addr;
      end
      if (ck_rise) begin
        cke_prev <= s_cke;
      end
      if (sr_go) begin
        sr_active <= 1'b1; // [R17]
      end else if (cke_up) begin
        sr_active <= 1'b0;
      end
      if (pd_go) begin
        pd_active <= 1'b1;
      end else if (cke_up) begin
        pd_active <= 1'b0;
      end
    end
  end

  // Access sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      cnt        <= 5'h00;
      slot       <= 3'h0;
      acc_write  <= 1'b0;
      acc_start  <= 3'h0;
      acc_chop   <= 1'b0;
      acc_fixed4 <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (new_acc) begin
            acc_write  <= ~s_we_n;
            acc_start  <= s_addr[2:0];
            acc_chop   <= new_chop;
            acc_fixed4 <= new_fixed4;
            if (al_val == 5'h00) begin
              state <= ST_CAS;
              cnt   <= new_lat - 5'h01;
            end else begin
              state <= ST_AL;
              cnt   <= al_val - 5'h01;
            end
          end
        end
        ST_AL: begin
          if (int_go) begin
            state <= ST_CAS;
            cnt   <= acc_lat - 5'h01;
          end else if (ck_rise) begin
            cnt <= cnt - 5'h01;
          end
        end
        ST_CAS: begin
          if (first_bt) begin
            state <= ST_BURST;
            slot  <= 3'h1;
          end else if (ck_rise) begin
            cnt <= cnt - 5'h01;
          end
        end
        ST_BURST: begin
          if (ck_edge) begin
            slot <= slot + 3'h1;
            if (slot == LAST_SLOT) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_cmd       <= 1'b0;
      int_cmd_write <= 1'b0;
      rd_beat       <= 1'b0;
      rd_col        <= 3'h0;
      dq_oe         <= 1'b0;
      wr_beat       <= 1'b0;
      wr_col        <= 3'h0;
      wr_care       <= 1'b0;
      wr_rec_start  <= 1'b0;
    end else begin
      int_cmd       <= int_go | (new_acc & (al_val == 5'h00)); // [R22]
      int_cmd_write <= int_go ? acc_write : ~s_we_n;
      rd_beat       <= emit & ~acc_write & rdrv;
      rd_col        <= emit ? rcol : rd_col;
      wr_beat       <= emit & acc_write;
      wr_col        <= emit ? wcol : wr_col;
      wr_care       <= emit & acc_write & ~(acc_chop & tail); // [R3]
      wr_rec_start  <= rec_hit; // [R4]
      if (emit) begin
        dq_oe <= ~acc_write & rdrv; // [R2]
      end else if (ck_edge) begin
        dq_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dll_run   <= 1'b0;
      exit_slow <= 1'b0;
      drv_imp   <= 2'h0;
      rtt_nom   <= 3'h0;
      wr_level  <= 1'b0;
      out_off   <= 1'b0;
      tdqs_en   <= 1'b0;
    end else begin
      dll_run   <= dll_on; // [R25]
      exit_slow <= ~mr0[MR0_PPD]; // [R12]
      drv_imp   <= {mr1[MR1_DIC_A5], mr1[MR1_DIC_A1]}; // [R20]
      rtt_nom   <= {mr1[MR1_RTT_A9], mr1[MR1_RTT_A6], mr1[MR1_RTT_A2]};
      wr_level  <= mr1[MR1_WLVL];
      out_off   <= mr1[MR1_QOFF];
      tdqs_en   <= mr1[MR1_TDQS];
    end
  end

endmodule

// *** tb/dmr_core_sva.sv ***
// Assertions for the mode register block ports
`timescale 1ns/1ps
module dmr_core_sva
  import dmr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rd_beat,
  input wire logic        dq_oe,
  input wire logic        wr_beat,
  input wire logic        wr_care,
  input wire logic        dll_reset,
  input wire logic        wr_rec_start,
  input wire logic        exit_slow,
  input wire logic [1:0]  drv_imp,
  input wire logic [2:0]  rtt_nom,
  input wire logic        wr_level,
  input wire logic        out_off
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire rd_acc = psel && penable && pready && !pwrite;

  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pslverr |-> pready && prdata == 32'h00000000; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_slow;
    rd_acc && paddr == REG_MR0 |-> prdata[12] != exit_slow;
  endproperty
  a_slow: assert property (p_slow) else $error("exit mode wrong");
  property p_imp;
    rd_acc && paddr == REG_MR1 |-> drv_imp == {prdata[5], prdata[1]}
      && wr_level == prdata[7] && out_off == prdata[12];
  endproperty
  a_imp: assert property (p_imp) else $error("impedance wrong");
  property p_rtt;
    rd_acc && paddr == REG_MR1 |-> rtt_nom == {prdata[9], prdata[6], prdata[2]};
  endproperty
  a_rtt: assert property (p_rtt) else $error("termination wrong");
  property p_oe; rd_beat |-> dq_oe; endproperty
  a_oe: assert property (p_oe) else $error("read beat undriven");
  property p_care; wr_care |-> wr_beat; endproperty
  a_care: assert property (p_care) else $error("care outside beat");
  property p_dllr; dll_reset |=> !dll_reset; endproperty
  a_dllr: assert property (p_dllr) else $error("dll reset stuck");
  c_rd: cover property (rd_beat);
  c_rec: cover property (wr_rec_start);
  c_dll: cover property (dll_reset);
endmodule

bind dmr_core dmr_core_sva u_sva (.sys_clk, .sys_rst, .paddr, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .rd_beat, .dq_oe, .wr_beat,
  .wr_care, .dll_reset, .wr_rec_start, .exit_slow, .drv_imp, .rtt_nom,
  .wr_level, .out_off);

// *** tb/dmr_ctl_model.sv ***
// Controller model that drives the DDR command pins
`timescale 1ns/1ps
module dmr_ctl_model (
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr
);
  initial begin
    {ck, cke, cs_n, ras_n, cas_n, we_n} = 6'b001111;
    ba = 3'h0;
    addr = 14'h0000;
    #3.3;
    forever #40 ck = ~ck;
  end
  task automatic power_up;
    @(negedge ck);
    cke = 1'b1;
  endtask
  // Moves clock enable at one link edge, with the command that goes along
  task automatic set_cke(input logic v, input logic [2:0] rcw);
    @(negedge ck);
    cke = v;
    {cs_n, ras_n, cas_n, we_n} = {1'b0, rcw};
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
  endtask
  task automatic issue(input logic [2:0] rcw, input logic [2:0] b,
                       input logic [13:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = {1'b0, rcw};
    ba = b;
    addr = a;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    // Released lines flip so stale values are never seen
    ba = ~b;
    addr = ~a;
  endtask
endmodule

// *** tb/tb_dram_mode_reg_burst_order.sv ***
// Self-checking bench for the DDR3 mode register block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_dram_mode_reg_burst_order
  import dmr_pkg::*;
;
  localparam int DLLK_WAIT = 64;
  localparam int CK_CYC    = 16;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        ck, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba, rd_col, wr_col, rtt_nom;
  logic [13:0] addr;
  logic        rd_beat, dq_oe, wr_beat, wr_care, wr_rec_start, dll_reset;
  logic        exit_slow, wr_level, out_off, tdqs_en;
  logic [1:0]  drv_imp;
  logic        int_cmd, int_cmd_write, dll_run, iw;
  int          cyc, t_int, t_bt, c_ret, n_int, n_oe;
  logic [3:0]  rq[$], wq[$];
  int          fails, n_checks, n_dllr, rec_at, k, s, i, bt, f, al, ch;
  int          wbl[4] = '{0, 2, 1, 1};
  int          wa12[4] = '{1, 0, 0, 1};
  int          wcol[4] = '{5, 6, 2, 3};

  dmr_core DUT (.sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .ck, .cke, .cs_n, .ras_n, .cas_n,
    .we_n, .ba, .addr, .int_cmd, .int_cmd_write, .rd_beat, .rd_col,
    .dq_oe, .wr_beat, .wr_col, .wr_care, .wr_rec_start, .dll_run,
    .dll_reset, .exit_slow, .drv_imp, .rtt_nom, .wr_level, .out_off, .tdqs_en);
  dmr_ctl_model u_ctl (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if ((rd_beat || wr_beat) && rq.size() + wq.size() == 0) t_bt = cyc;
    if (int_cmd) begin
      n_int++;
      t_int = cyc;
      iw = int_cmd_write;
    end
    if (dq_oe) n_oe++;
    if (rd_beat) rq.push_back({1'b0, rd_col});
    if (wr_beat) wq.push_back({wr_care, wr_col});
    if (wr_rec_start) rec_at = wq.size();
    if (dll_reset) n_dllr++;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    u_ctl.issue(3'b000, b, a);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic burst(input logic [2:0] rcw, input logic [13:0] a, int n);
    rq.delete();
    wq.delete();
    rec_at = 0;
    n_int = 0;
    n_oe = 0;
    u_ctl.issue(rcw, 3'b000, a);
    c_ret = cyc;
    for (int j = 0; j < 600 && rq.size() + wq.size() < n; j++)
      @(posedge sys_clk);
    repeat (80) @(posedge sys_clk);
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    u_ctl.power_up();
    apb(0, REG_CTRL, 0);
    `CHK(q[3:0], CWL_RESET)
    apb(0, 8'h10, 0);
    `CHK({e, q}, {1'b1, 32'h00000000})
    apb(1, REG_CTRL, 0);
    apb(0, REG_CTRL, 0);
    `CHK(q[3:0], 4'h1)
    apb(1, REG_CTRL, 32'h00000005);
    mrs(3'b001, 14'h1286);
    `CHK({drv_imp, rtt_nom, wr_level, out_off, tdqs_en}, 8'h6E)
    apb(0, REG_MR1, 0);
    `CHK(q[13:0], 14'h1286)
    mrs(3'b000, 14'h0310);
    `CHK(n_dllr, 1)
    apb(0, REG_MR0, 0);
    `CHK(q[13:0], 14'h0210)
    `CHK(exit_slow, 1'b1)
    repeat (DLLK_WAIT) @(posedge sys_clk);
    for (k = 0; k < 4; k++) begin
      mrs(3'b001, 14'(k * 8 + (k == 3)));
      apb(0, REG_STATUS, 0);
      al = (k == 1) ? 4 : (k == 2) ? 3 : 0;
      `CHK(q[25:0], {6'(al + 5), 6'(al + 5), 5'(al), 5'h05, 2'h0,
        1'(k == 3), 1'(k != 3)})
      `CHK(dll_run, 1'(k != 3))
    end
    mrs(3'b001, 14'h0000);
    `CHK(dll_run, 1'b1)
    u_ctl.set_cke(1'b0, 3'b001);
    `CHK(dll_run, 1'b0)
    u_ctl.set_cke(1'b1, 3'b111);
    `CHK(dll_run, 1'b1)
    u_ctl.set_cke(1'b0, 3'b111);
    `CHK(dll_run, 1'b0)
    u_ctl.set_cke(1'b1, 3'b111);
    `CHK(dll_run, 1'b1)
    for (bt = 0; bt < 2; bt++) begin
      for (f = 0; f < 2; f++) begin
        mrs(3'b000, 14'(16 + bt * 4104 + f * 2));
        `CHK(exit_slow, 1'(bt == 0))
        for (s = 0; s < 8; s++) begin
          burst(3'b101, 14'(4096 + s), f ? 4 : 8);
          `CHK(rq.size(), f ? 4 : 8)
          `CHK(n_oe, (f ? 4 : 8) * CK_CYC / 2)
          for (i = 0; i < 8 - 4 * f; i++)
            `CHK(rq[i], 4'(bt ? s ^ i : ((s & 4) | ((s + i) & 3)) ^ (i & 4)))
        end
      end
    end
    for (k = 0; k < 4; k++) begin
      mrs(3'b000, 14'(16 + wbl[k]));
      burst(3'b100, 14'(wa12[k] * 4096 + wcol[k]), 8);
      ch = (wbl[k] == 2) || (wbl[k] == 1 && wa12[k] == 0);
      for (i = 0; i < 8; i++)
        `CHK(wq[i], 4'({!ch || i < 4, 3'(ch ? (wcol[k] & 4) | (i & 3) : i)}))
      `CHK(rec_at, wbl[k] == 2 ? 4 : 8)
    end
    mrs(3'b000, 14'h0010);
    for (k = 0; k < 4; k++) begin
      al = (k & 1) * 4;
      mrs(3'b001, 14'((k & 1) * 8));
      burst((k < 2) ? 3'b101 : 3'b100, 14'h0000, 8);
      `CHK(n_int, 1)
      `CHK(iw, 1'(k >= 2))
      `CHK(t_bt - t_int, 5 * CK_CYC)
      `CHK((t_int - c_ret + CK_CYC / 2 - al * CK_CYC) inside {[0:7]}, 1'b1)
    end
    mrs(3'b001, 14'h0000);
    summarize();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule
